// ---- rtl/ras_pkg.sv ----
// Overview of operation
// - stack is 31 entries of 21 bits, five-bit pointer cleared by every reset
// - pointer zero means empty; entries live at pointer values one to 31
// - push increments pointer, then writes program counter at new pointer
// - pop copies entry at current pointer to program counter, then decrements
// - call, relative call, interrupt acknowledge push; returns of all kinds pop
// - call and return never alter the upper and high pc latch registers
// - three top entry registers read and write the entry at the pointer
// - pointer holds 0 to 31 and software reads and writes it
// - full flag sets after 31 pushes with no pop between
// - with reset enable, 31st push stores pc plus two, sets full, resets device
// - without reset enable, 31st push sets full, pointer 31, further pushes ignored
// - pop at pointer zero returns zero, sets underflow, pointer stays zero
// - full or underflow requests device reset only when reset enable is set
// - flags are sticky; cleared only by software write of zero or power-on
// - status register: full bit 7, underflow bit 6, bit 5 zero, pointer 4..0
// - software push increments pointer and stores pc at the new top
// - software pop decrements pointer and leaves program counter alone
// - one-deep shadow of status, working and bank select loaded on any interrupt
// - fast return from interrupt restores status, working and bank select
// - every interrupt overwrites the shadow, high over low priority alike
// - fast call saves the shadow, fast return restores from it
package ras_pkg;
	localparam int             DEPTH         = 31;
	localparam int             PC_W          = 21;
	localparam int             PTR_W         = 5;
	localparam logic [4:0]     PTR_EMPTY     = 5'h00;
	localparam logic [4:0]     PTR_MAX       = 5'h1F;
	localparam logic [20:0]    PC_STEP       = 21'h000002;
	localparam logic [2:0]     ADDR_STATUS   = 3'h0;
	localparam logic [2:0]     ADDR_TOP_LOW  = 3'h1;
	localparam logic [2:0]     ADDR_TOP_HIGH = 3'h2;
	localparam logic [2:0]     ADDR_TOP_UP   = 3'h3;
	localparam int             BIT_FULL      = 7;
	localparam int             BIT_UNDER     = 6;
	localparam logic [7:0]     STATUS_RESET  = 8'h00;
	localparam logic [4:0]     UPPER_MASK    = 5'h1F;

	typedef enum logic [2:0] {
		OP_NONE, OP_CALL, OP_RELATIVE_CALL, OP_INT_ACK, OP_RETURN, OP_RET_LIT, OP_RET_INT,
		OP_SW_PUSH
	} ras_op_type;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working;
		logic [7:0] bank;
	} ras_ctx_type;

	typedef struct packed {
		ras_op_type  op;
		logic        fast;
		logic        sw_pop;
		logic [20:0] pc;
		ras_ctx_type ctx;
	} ras_cmd_type;

	typedef struct packed {
		logic        pc_valid;
		logic [20:0] pc;
		logic        ctx_valid;
		ras_ctx_type ctx;
		logic        reset_req;
	} ras_rsp_type;
endpackage

// ---- rtl/ras_stack.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module ras_stack (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              por,
	// configuration
	input  wire logic              stack_error_reset_enable,
	// sequencer
	input  wire ras_pkg::ras_cmd_type cmd,
	output ras_pkg::ras_rsp_type   rsp,
	// register port
	input  wire logic [2:0]        addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [7:0]             rdata
);
	typedef struct packed {
		logic [4:0]           ptr;
		logic                 full;
		logic                 under;
		ras_pkg::ras_ctx_type shadow;
		ras_pkg::ras_rsp_type rsp;
		logic [7:0]           rdata;
	} ras_state_type;

	ras_state_type state;
	ras_state_type next_state;
	logic [20:0]   mem [1:31];
	logic          mem_we;
	logic [4:0]    mem_wa;
	logic [20:0]   mem_wd;
	logic [20:0]   top;
	logic          is_push;
	logic          is_pop;

	assign top = (state.ptr == ras_pkg::PTR_EMPTY) ? 21'h000000 : mem[state.ptr];

	always_comb begin
		next_state = state;
		next_state.rsp.pc_valid = 1'b0;
		next_state.rsp.ctx_valid = 1'b0;
		next_state.rsp.reset_req = 1'b0;
		next_state.rdata = 8'h00;
		mem_we = 1'b0;
		mem_wa = state.ptr;
		mem_wd = cmd.pc;
		is_push = cmd.op inside {ras_pkg::OP_CALL, ras_pkg::OP_RELATIVE_CALL,
			ras_pkg::OP_INT_ACK, ras_pkg::OP_SW_PUSH};
		is_pop = cmd.op inside {ras_pkg::OP_RETURN, ras_pkg::OP_RET_LIT,
			ras_pkg::OP_RET_INT};
		// software register access; writes to flags may only clear
		if (wr) begin
			unique case (addr)
				ras_pkg::ADDR_STATUS: begin
					next_state.ptr = wdata[4:0];
					next_state.full = state.full & wdata[ras_pkg::BIT_FULL];
					next_state.under = state.under & wdata[ras_pkg::BIT_UNDER];
				end
				ras_pkg::ADDR_TOP_LOW: begin
					mem_we = state.ptr != ras_pkg::PTR_EMPTY;
					mem_wd = {top[20:8], wdata};
				end
				ras_pkg::ADDR_TOP_HIGH: begin
					mem_we = state.ptr != ras_pkg::PTR_EMPTY;
					mem_wd = {top[20:16], wdata, top[7:0]};
				end
				ras_pkg::ADDR_TOP_UP: begin
					mem_we = state.ptr != ras_pkg::PTR_EMPTY;
					mem_wd = {wdata[4:0] & ras_pkg::UPPER_MASK, top[15:0]};
				end
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				ras_pkg::ADDR_STATUS: next_state.rdata =
					{state.full, state.under, 1'b0, state.ptr};
				ras_pkg::ADDR_TOP_LOW: next_state.rdata = top[7:0];
				ras_pkg::ADDR_TOP_HIGH: next_state.rdata = top[15:8];
				ras_pkg::ADDR_TOP_UP: next_state.rdata = {3'h0, top[20:16]};
				default: next_state.rdata = 8'h00;
			endcase
		end
		// sequencer operations take the stack after software access
		if (is_push) begin
			if (state.ptr == ras_pkg::PTR_MAX) begin
				next_state.full = 1'b1;
			end else begin
				next_state.ptr = state.ptr + 5'h01;
				mem_we = 1'b1;
				mem_wa = state.ptr + 5'h01;
				mem_wd = cmd.pc;
				if (state.ptr == ras_pkg::PTR_MAX - 5'h01) begin
					next_state.full = 1'b1;
					if (stack_error_reset_enable) begin
						mem_wd = cmd.pc + ras_pkg::PC_STEP;
						next_state.rsp.reset_req = 1'b1;
					end
				end
			end
		end else if (is_pop) begin
			next_state.rsp.pc_valid = 1'b1;
			next_state.rsp.pc = top;
			if (state.ptr == ras_pkg::PTR_EMPTY) begin
				next_state.under = 1'b1;
				next_state.rsp.reset_req = stack_error_reset_enable;
			end else begin
				next_state.ptr = state.ptr - 5'h01;
			end
		end else if (cmd.sw_pop && state.ptr != ras_pkg::PTR_EMPTY) begin
			next_state.ptr = state.ptr - 5'h01;
		end
		// shadow registers
		if (cmd.op == ras_pkg::OP_INT_ACK || (cmd.op == ras_pkg::OP_CALL && cmd.fast)) begin
			next_state.shadow = cmd.ctx;
		end
		if (cmd.fast && (cmd.op == ras_pkg::OP_RET_INT || cmd.op == ras_pkg::OP_RETURN)) begin
			next_state.rsp.ctx_valid = 1'b1;
			next_state.rsp.ctx = state.shadow;
		end
	end

	always_ff @(posedge clock) begin
		state <= next_state;
		if (rst) begin
			state.ptr <= ras_pkg::PTR_EMPTY;
			state.rsp <= '0;
			state.rdata <= 8'h00;
			// flags survive stack resets, power-on clears them
			if (por) begin
				state.full <= 1'b0;
				state.under <= 1'b0;
			end
		end
		if (mem_we && !rst) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	assign rsp = state.rsp;
	assign rdata = state.rdata;

	underflow_pop_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop && !wr && state.ptr == 5'h00)
		|=> (state.under && state.ptr == 5'h00 && state.rsp.pc == 21'h000000))
		else $error("underflow pop wrong");

	push_incr_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && !wr && state.ptr < 5'h1F)
		|=> state.ptr == $past(state.ptr) + 5'h01)
		else $error("push did not increment");

	pop_value_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop && !wr && state.ptr != 5'h00) |=> (state.rsp.pc_valid
		&& state.rsp.pc == mem[$past(state.ptr)] && state.ptr == $past(state.ptr) - 5'h01))
		else $error("pop value or pointer wrong");

	full_hold_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && state.ptr == 5'h1F && !wr)
		|=> (state.full && state.ptr == 5'h1F))
		else $error("push at full moved pointer");

	full_set_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && state.ptr == 5'h1E)
		|=> state.full)
		else $error("full not set");

	error_reset_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && state.ptr == 5'h1E && stack_error_reset_enable)
		|=> state.rsp.reset_req)
		else $error("no reset request");

	flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
		(state.full && !(wr && addr == ras_pkg::ADDR_STATUS))
		|=> state.full)
		else $error("full flag dropped");

	fast_restore_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.fast && cmd.op == ras_pkg::OP_RET_INT)
		|=> (state.rsp.ctx_valid && state.rsp.ctx == $past(state.shadow)))
		else $error("shadow not restored");

	sw_pop_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.sw_pop && cmd.op == ras_pkg::OP_NONE && !wr && state.ptr != 5'h00)
		|=> (!state.rsp.pc_valid && state.ptr == $past(state.ptr) - 5'h01))
		else $error("software pop wrong");

	push_write_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && !wr && state.ptr < 5'h1E)
		|=> mem[state.ptr] == $past(cmd.pc))
		else $error("push wrote wrong entry");

	push_plus_two_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && !wr && state.ptr == 5'h1E && stack_error_reset_enable)
		|=> mem[31] == $past(cmd.pc) + ras_pkg::PC_STEP)
		else $error("last push did not store pc plus two");

	push_plain_last_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && !wr && state.ptr == 5'h1E && !stack_error_reset_enable)
		|=> mem[31] == $past(cmd.pc))
		else $error("last push stored wrong value");

	full_no_write_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && !wr && state.ptr == 5'h1F)
		|=> mem[31] == $past(mem[31]))
		else $error("push at full overwrote entry");

	full_no_reset_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && state.ptr == 5'h1E && !stack_error_reset_enable)
		|=> !state.rsp.reset_req)
		else $error("full requested reset while disabled");

	under_reset_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop && state.ptr == 5'h00 && stack_error_reset_enable)
		|=> state.rsp.reset_req)
		else $error("underflow did not request reset");

	under_no_reset_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop && state.ptr == 5'h00 && !stack_error_reset_enable)
		|=> !state.rsp.reset_req)
		else $error("underflow requested reset while disabled");

	under_set_wins_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop && state.ptr == 5'h00)
		|=> state.under)
		else $error("underflow flag lost to clear");

	full_set_wins_a: assert property (@(posedge clock) disable iff (rst)
		(is_push && state.ptr == 5'h1F)
		|=> state.full)
		else $error("full flag lost to clear");

	under_sticky_a: assert property (@(posedge clock) disable iff (rst)
		(state.under && !(wr && addr == ras_pkg::ADDR_STATUS))
		|=> state.under)
		else $error("underflow flag dropped");

	full_never_set_a: assert property (@(posedge clock) disable iff (rst)
		(!state.full && !is_push)
		|=> !state.full)
		else $error("full flag set without push");

	under_never_set_a: assert property (@(posedge clock) disable iff (rst)
		(!state.under && !is_pop)
		|=> !state.under)
		else $error("underflow flag set without pop");

	full_clear_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_STATUS && !wdata[ras_pkg::BIT_FULL] && !is_push)
		|=> !state.full)
		else $error("full flag not cleared");

	under_clear_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_STATUS && !wdata[ras_pkg::BIT_UNDER] && !is_pop)
		|=> !state.under)
		else $error("underflow flag not cleared");

	ptr_write_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_STATUS && cmd.op == ras_pkg::OP_NONE && !cmd.sw_pop)
		|=> state.ptr == $past(wdata[4:0]))
		else $error("pointer write lost");

	ptr_hold_a: assert property (@(posedge clock) disable iff (rst)
		(!(wr && addr == ras_pkg::ADDR_STATUS) && cmd.op == ras_pkg::OP_NONE && !cmd.sw_pop)
		|=> $stable(state.ptr))
		else $error("pointer moved while idle");

	status_gap_a: assert property (@(posedge clock) disable iff (rst)
		(rd && addr == ras_pkg::ADDR_STATUS)
		|=> (rdata[5] == 1'b0 && rdata[4:0] == $past(state.ptr)))
		else $error("status read wrong");

	read_low_a: assert property (@(posedge clock) disable iff (rst)
		(rd && addr == ras_pkg::ADDR_TOP_LOW)
		|=> rdata == $past(top[7:0]))
		else $error("low top read wrong");

	read_high_a: assert property (@(posedge clock) disable iff (rst)
		(rd && addr == ras_pkg::ADDR_TOP_HIGH)
		|=> rdata == $past(top[15:8]))
		else $error("high top read wrong");

	read_up_a: assert property (@(posedge clock) disable iff (rst)
		(rd && addr == ras_pkg::ADDR_TOP_UP)
		|=> rdata == {3'h0, $past(top[20:16])})
		else $error("upper top read wrong");

	read_empty_a: assert property (@(posedge clock) disable iff (rst)
		(rd && addr != ras_pkg::ADDR_STATUS && state.ptr == ras_pkg::PTR_EMPTY)
		|=> rdata == 8'h00)
		else $error("empty stack read not zero");

	read_idle_a: assert property (@(posedge clock) disable iff (rst)
		(!rd)
		|=> rdata == 8'h00)
		else $error("read data without read");

	write_low_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_TOP_LOW && state.ptr != 5'h00 && cmd.op == ras_pkg::OP_NONE)
		|=> mem[state.ptr][7:0] == $past(wdata))
		else $error("low top write lost");

	write_high_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_TOP_HIGH && state.ptr != 5'h00 && cmd.op == ras_pkg::OP_NONE)
		|=> mem[state.ptr][15:8] == $past(wdata))
		else $error("high top write lost");

	write_up_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_TOP_UP && state.ptr != 5'h00 && cmd.op == ras_pkg::OP_NONE)
		|=> mem[state.ptr][20:16] == $past(wdata[4:0]))
		else $error("upper top write lost");

	write_keep_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr == ras_pkg::ADDR_TOP_LOW && state.ptr != 5'h00 && cmd.op == ras_pkg::OP_NONE)
		|=> mem[state.ptr][20:8] == $past(top[20:8]))
		else $error("low write disturbed upper bits");

	write_empty_a: assert property (@(posedge clock) disable iff (rst)
		(wr && addr != ras_pkg::ADDR_STATUS && state.ptr == 5'h00 && cmd.op == ras_pkg::OP_NONE)
		|=> mem[1] == $past(mem[1]))
		else $error("write at empty pointer reached ram");

	pop_pulse_a: assert property (@(posedge clock) disable iff (rst)
		(is_pop)
		|=> state.rsp.pc_valid)
		else $error("pop gave no pc");

	pc_valid_only_a: assert property (@(posedge clock) disable iff (rst)
		(!is_pop)
		|=> !state.rsp.pc_valid)
		else $error("pc answer without pop");

	push_quiet_a: assert property (@(posedge clock) disable iff (rst)
		(is_push)
		|=> (!state.rsp.pc_valid && !state.rsp.ctx_valid))
		else $error("push drove an answer");

	shadow_int_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.op == ras_pkg::OP_INT_ACK)
		|=> state.shadow == $past(cmd.ctx))
		else $error("interrupt did not load shadow");

	shadow_call_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.op == ras_pkg::OP_CALL && cmd.fast)
		|=> state.shadow == $past(cmd.ctx))
		else $error("fast call did not load shadow");

	shadow_keep_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.op == ras_pkg::OP_RETURN)
		|=> state.shadow == $past(state.shadow))
		else $error("return changed shadow");

	fast_return_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.fast && cmd.op == ras_pkg::OP_RETURN)
		|=> (state.rsp.ctx_valid && state.rsp.ctx == $past(state.shadow)))
		else $error("fast return did not restore");

	no_restore_a: assert property (@(posedge clock) disable iff (rst)
		(!cmd.fast)
		|=> !state.rsp.ctx_valid)
		else $error("restore without fast option");

	sw_pop_empty_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.sw_pop && cmd.op == ras_pkg::OP_NONE && !wr && state.ptr == 5'h00)
		|=> (state.ptr == 5'h00 && $stable(state.under)))
		else $error("software pop at empty moved state");

	sw_push_a: assert property (@(posedge clock) disable iff (rst)
		(cmd.op == ras_pkg::OP_SW_PUSH && !wr && state.ptr < 5'h1E)
		|=> (state.ptr == $past(state.ptr) + 5'h01 && mem[state.ptr] == $past(cmd.pc)))
		else $error("software push wrong");

	reset_ptr_a: assert property (@(posedge clock)
		(rst)
		|=> (state.ptr == ras_pkg::PTR_EMPTY && !state.rsp.pc_valid && rdata == 8'h00))
		else $error("reset left pointer or outputs set");

	reset_flags_a: assert property (@(posedge clock)
		(rst && !por)
		|=> (state.full == $past(state.full) && state.under == $past(state.under)))
		else $error("stack reset changed flags");

	por_clear_a: assert property (@(posedge clock)
		(rst && por)
		|=> (!state.full && !state.under))
		else $error("power-on reset left flags set");
endmodule // ras_stack

// ---- dv/ras_seq_model.sv ----
`timescale 1ns/100ps
module ras_seq_model (
	// clock
	input  wire logic                 clock,
	// device side
	input  wire ras_pkg::ras_rsp_type rsp,
	output ras_pkg::ras_cmd_type      cmd,
	output logic                      dev_rst
);
	ras_pkg::ras_rsp_type last;
	initial begin
		cmd = '0;
	end
	// a requested device reset is applied at the next edge
	always_ff @(posedge clock) begin
		dev_rst <= rsp.reset_req;
	end
	// one op per cycle; the answer is caught in the cycle after the take edge
	task automatic issue(input ras_pkg::ras_op_type op, input logic fast,
		input logic [20:0] pc, input logic [23:0] ctx);
		@(posedge clock);
		cmd <= '{op: op, fast: fast, sw_pop: 1'b0, pc: pc, ctx: ctx};
		@(posedge clock);
		cmd <= '0;
		#1 last = rsp;
	endtask
	// software pop: one cycle of sw_pop with no sequencer op
	task automatic discard;
		@(posedge clock);
		cmd <= '{op: ras_pkg::OP_NONE, fast: 1'b0, sw_pop: 1'b1, pc: 21'h0, ctx: 24'h0};
		@(posedge clock);
		cmd <= '0;
		#1 last = rsp;
	endtask
endmodule // ras_seq_model

// ---- dv/test_return_address_stack.sv ----
`timescale 1ns/100ps
module test_return_address_stack;
	logic                 clock, rst, en, wr, rd, dev_rst;
	logic [2:0]           addr;
	logic [7:0]           wdata, rdata;
	int                   bad_count, n_checks, cyc;
	ras_pkg::ras_cmd_type cmd;
	ras_pkg::ras_rsp_type rsp;
	ras_stack DUT (.clock(clock), .rst(rst | dev_rst), .por(rst),
		.stack_error_reset_enable(en), .cmd(cmd), .rsp(rsp), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	ras_seq_model SEQ (.clock(clock), .rsp(rsp), .cmd(cmd), .dev_rst(dev_rst));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic chk_top(input logic [20:0] exp);
		rd_reg(3'h1, exp[7:0]);
		rd_reg(3'h2, exp[15:8]);
		rd_reg(3'h3, {3'h0, exp[20:16]});
	endtask
	task automatic sc_push_pop;
		SEQ.issue(ras_pkg::OP_CALL, 1'b0, 21'h012344, 24'h0);
		SEQ.issue(ras_pkg::OP_RELATIVE_CALL, 1'b0, 21'h00ABCC, 24'h0);
		rd_reg(3'h0, 8'h02);
		chk_top(21'h00ABCC);
		wr_reg(3'h1, 8'h5A);
		SEQ.issue(ras_pkg::OP_RET_LIT, 1'b0, 21'h0, 24'h0);
		chk({SEQ.last.pc_valid, SEQ.last.pc}, {1'b1, 21'h00AB5A});
		SEQ.issue(ras_pkg::OP_INT_ACK, 1'b0, 21'h000300, 24'h0);
		SEQ.issue(ras_pkg::OP_RET_INT, 1'b0, 21'h0, 24'h0);
		chk(SEQ.last.pc, 21'h000300);
		SEQ.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 24'h0);
		chk(SEQ.last.pc, 21'h012344);
		rd_reg(3'h0, 8'h00);
	endtask
	task automatic sc_underflow;
		SEQ.issue(ras_pkg::OP_RETURN, 1'b0, 21'h000456, 24'h0);
		chk({SEQ.last.pc_valid, SEQ.last.pc, SEQ.last.reset_req}, 23'h400000);
		rd_reg(3'h0, 8'h40);
		wr_reg(3'h0, 8'hFF);
		rd_reg(3'h0, 8'h5F);
		wr_reg(3'h0, 8'h00);
		rd_reg(3'h0, 8'h00);
	endtask
	task automatic sc_full;
		for (int i = 1; i <= 31; i++) begin
			SEQ.issue(ras_pkg::OP_CALL, 1'b0, 21'(i * 2), 24'h0);
		end
		rd_reg(3'h0, 8'h9F);
		SEQ.issue(ras_pkg::OP_CALL, 1'b0, 21'h00007E, 24'h0);
		rd_reg(3'h0, 8'h9F);
		chk_top(21'h00003E);
		wr_reg(3'h0, 8'h00);
	endtask
	task automatic sc_fast;
		SEQ.issue(ras_pkg::OP_CALL, 1'b1, 21'h000010, 24'hA1B2C3);
		SEQ.issue(ras_pkg::OP_RETURN, 1'b1, 21'h0, 24'h0);
		chk({SEQ.last.ctx_valid, SEQ.last.ctx}, 25'h1A1B2C3);
		SEQ.issue(ras_pkg::OP_INT_ACK, 1'b0, 21'h000020, 24'h112233);
		SEQ.issue(ras_pkg::OP_INT_ACK, 1'b0, 21'h000040, 24'h445566);
		SEQ.issue(ras_pkg::OP_RET_INT, 1'b1, 21'h0, 24'h0);
		chk({SEQ.last.ctx_valid, SEQ.last.ctx}, 25'h1445566);
		SEQ.issue(ras_pkg::OP_RET_INT, 1'b0, 21'h0, 24'h0);
	endtask
	task automatic sc_software;
		wr_reg(3'h1, 8'h77);
		chk_top(21'h000000);
		SEQ.issue(ras_pkg::OP_SW_PUSH, 1'b0, 21'h000222, 24'h0);
		chk_top(21'h000222);
		wr_reg(3'h3, 8'h01);
		SEQ.issue(ras_pkg::OP_CALL, 1'b0, 21'h000444, 24'h0);
		SEQ.discard;
		chk(SEQ.last.pc_valid, 1'b0);
		rd_reg(3'h0, 8'h01);
		SEQ.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 24'h0);
		chk(SEQ.last.pc, 21'h010222);
		SEQ.discard;
		rd_reg(3'h0, 8'h00);
	endtask
	task automatic sc_error_reset;
		@(posedge clock);
		en <= 1'b1;
		SEQ.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 24'h0);
		chk(SEQ.last.reset_req, 1'b1);
		// let the requested device reset pass before touching the pointer
		repeat (3) @(posedge clock);
		wr_reg(3'h0, 8'h5E);
		SEQ.issue(ras_pkg::OP_CALL, 1'b0, 21'h000100, 24'h0);
		chk(SEQ.last.reset_req, 1'b1);
		repeat (3) @(posedge clock);
		rd_reg(3'h0, 8'hC0);
		wr_reg(3'h0, 8'hDF);
		chk_top(21'h000102);
		wr_reg(3'h0, 8'h00);
		en <= 1'b0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// cut a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		{rst, en, wr, rd, addr, wdata} = {1'b1, 14'h0};
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd_reg(3'h0, 8'h00);
		sc_push_pop;
		sc_underflow;
		sc_full;
		sc_fast;
		sc_software;
		sc_error_reset;
		complete_run;
	end
endmodule // test_return_address_stack
